// >>> hdl/dmh_top.sv
/*
 Diagnostic monitor hub: monitor cells, alert routing, fail-safe shutdown,
 crystal switchover, CRC checks, register scrub, self test, AXI4-Lite slave.
 Assumes all inputs synchronous to CLK and an external open-drain pad.
*/
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dmh_top #(
  parameter int SCRUB_CYCLES = dmh_pkg::SCRUB_CYCLES
) (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RST,
  // AXI4-Lite slave.
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Monitor inputs.
  input wire logic [1:0] XTAL_LOS,
  input wire logic [15:0] PPM_DIFF,
  input wire logic PLL_LOCK,
  input wire logic [11:0] OUT_FREQ_ERR,
  // Serial access byte stream; the last byte is its CRC.
  input wire logic SER_VALID,
  input wire logic [7:0] SER_BYTE,
  input wire logic SER_LAST,
  // Image download word stream; the last word is its CRC.
  input wire logic OTP_VALID,
  input wire logic [31:0] OTP_WORD,
  input wire logic OTP_LAST,
  // Controls to the clock path.
  output logic XTAL_SEL,
  output logic [11:0] CLK_OE,
  // Open-drain general purpose pins.
  output logic [6:0] GPIO_O,
  output logic [6:0] GPIO_OE
);
  localparam int NM = dmh_pkg::NMON;
  localparam int NO = dmh_pkg::NOUT;
  localparam int NGPIO = dmh_pkg::NGPIO;
  localparam logic [16:0] SCRUB_LAST = 17'(SCRUB_CYCLES - 1);

  logic [31:0] ctrl_q, mon_en_q, route_q, inject_q, out_en_q, ppm_lim_q, pin_sel_q;
  logic [NM-1:0] raw, hit, flag, clr_status, inj;
  logic [NO-1:0] out_err_q, clr_out;
  logic notify_act, safe_act, post_done, post_fail_q, active_q, swap_ev;
  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave. Address and data may arrive in either order.

  logic aw_full_q, w_full_q, wr_go, ar_go;
  logic [7:0] awaddr_q, araddr_d;
  logic [31:0] wdata_q, rdata_d;
  logic [3:0] wstrb_q;
  logic wr_map, rd_map;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  assign S_AXI_AWREADY = !aw_full_q && !S_AXI_BVALID;
  assign S_AXI_WREADY = !w_full_q && !S_AXI_BVALID;
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  assign wr_go = aw_full_q && w_full_q && !S_AXI_BVALID;
  assign ar_go = S_AXI_ARVALID && S_AXI_ARREADY;
  assign araddr_d = S_AXI_ARADDR;

  always_ff @(posedge CLK) begin
    if (RST) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= dmh_pkg::RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_full_q <= 1'b1;
        awaddr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_full_q <= 1'b1;
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
      end
      if (wr_go) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_map ? dmh_pkg::RESP_OKAY : dmh_pkg::RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  always_comb begin
    wr_map = 1'b1;
    case ({awaddr_q[7:2], 2'b00})
      dmh_pkg::A_CTRL, dmh_pkg::A_MON_EN, dmh_pkg::A_ROUTE, dmh_pkg::A_INJECT,
      dmh_pkg::A_STATUS, dmh_pkg::A_OUT_EN, dmh_pkg::A_OUT_ERR, dmh_pkg::A_PPM_LIM,
      dmh_pkg::A_PIN_SEL, dmh_pkg::A_STATE: wr_map = 1'b1;
      default: wr_map = 1'b0;
    endcase
  end

  // Each configuration register is one concern written from the bus only.
  function automatic logic hit_at(input logic [7:0] a, input logic [7:0] target);
    return {a[7:2], 2'b00} == target;
  endfunction : hit_at

  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl_q <= dmh_pkg::RST_CTRL;
      mon_en_q <= dmh_pkg::RST_MON_EN;
      route_q <= dmh_pkg::RST_ROUTE;
      inject_q <= 32'h0000_0000;
      out_en_q <= dmh_pkg::RST_OUT_EN;
      ppm_lim_q <= dmh_pkg::RST_PPM_LIM;
      pin_sel_q <= dmh_pkg::RST_PIN_SEL;
    end else if (wr_go) begin
      if (hit_at(awaddr_q, dmh_pkg::A_CTRL)) ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
      if (hit_at(awaddr_q, dmh_pkg::A_MON_EN)) mon_en_q <= merge(mon_en_q, wdata_q, wstrb_q);
      if (hit_at(awaddr_q, dmh_pkg::A_ROUTE)) route_q <= merge(route_q, wdata_q, wstrb_q);
      if (hit_at(awaddr_q, dmh_pkg::A_INJECT)) inject_q <= merge(inject_q, wdata_q, wstrb_q);
      if (hit_at(awaddr_q, dmh_pkg::A_OUT_EN)) out_en_q <= merge(out_en_q, wdata_q, wstrb_q);
      if (hit_at(awaddr_q, dmh_pkg::A_PPM_LIM)) ppm_lim_q <= merge(ppm_lim_q, wdata_q, wstrb_q);
      if (hit_at(awaddr_q, dmh_pkg::A_PIN_SEL)) pin_sel_q <= merge(pin_sel_q, wdata_q, wstrb_q);
    end
  end

  // Write-one-to-clear strobes for the sticky flags.
  assign clr_status = (wr_go && hit_at(awaddr_q, dmh_pkg::A_STATUS)) ? NM'(merge(32'h0, wdata_q, wstrb_q)) : '0;
  assign clr_out = (wr_go && hit_at(awaddr_q, dmh_pkg::A_OUT_ERR)) ? NO'(merge(32'h0, wdata_q, wstrb_q)) : '0;

  always_comb begin
    rdata_d = 32'h0000_0000;
    rd_map = 1'b1;
    case ({araddr_d[7:2], 2'b00})
      dmh_pkg::A_CTRL: rdata_d = ctrl_q;
      dmh_pkg::A_MON_EN: rdata_d = mon_en_q;
      dmh_pkg::A_ROUTE: rdata_d = route_q;
      dmh_pkg::A_INJECT: rdata_d = inject_q;
      dmh_pkg::A_STATUS: rdata_d = 32'(flag);
      dmh_pkg::A_OUT_EN: rdata_d = out_en_q;
      dmh_pkg::A_OUT_ERR: rdata_d = 32'(out_err_q);
      dmh_pkg::A_PPM_LIM: rdata_d = ppm_lim_q;
      dmh_pkg::A_PIN_SEL: rdata_d = pin_sel_q;
      dmh_pkg::A_STATE: begin
        rdata_d[dmh_pkg::B_ACT] = active_q;
        rdata_d[dmh_pkg::B_SAFE] = safe_act;
        rdata_d[dmh_pkg::B_PDONE] = post_done;
        rdata_d[dmh_pkg::B_PFAIL] = post_fail_q;
        rdata_d[dmh_pkg::B_LOCK] = PLL_LOCK;
      end
      default: rd_map = 1'b0;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= dmh_pkg::RESP_OKAY;
    end else if (ar_go) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rdata_d;
      S_AXI_RRESP <= rd_map ? dmh_pkg::RESP_OKAY : dmh_pkg::RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // CRC checks on serial accesses, image download and register scrub.

  logic [7:0] ser_crc_q, ser_crc_d;
  logic [31:0] otp_crc_q, otp_crc_d, otp_c_in, otp_c_dat;
  logic [31:0] scr_crc_q, scr_crc_d, scr_ref_q, scr_word, scr_c_in, scr_c_dat;
  logic [16:0] scr_tmr_q;
  logic [2:0] scr_idx_q;
  logic scr_run_q, scr_dirty_q, ser_err_q, otp_err_q, reg_err_q;

  dmh_crc #(.CW(8), .DW(8), .POLY(dmh_pkg::CRC8_POLY)) u_crc8 (
    .crc_in(ser_crc_q), .data(SER_BYTE), .crc_out(ser_crc_d));
  dmh_crc #(.CW(32), .DW(32), .POLY(dmh_pkg::CRC32_POLY)) u_crc_otp (
    .crc_in(otp_c_in), .data(otp_c_dat), .crc_out(otp_crc_d));
  dmh_crc #(.CW(32), .DW(32), .POLY(dmh_pkg::CRC32_POLY)) u_crc_scr (
    .crc_in(scr_c_in), .data(scr_c_dat), .crc_out(scr_crc_d));

  always_ff @(posedge CLK) begin
    if (RST) begin
      ser_crc_q <= dmh_pkg::CRC8_INIT;
      ser_err_q <= 1'b0;
    end else begin
      ser_err_q <= SER_VALID && SER_LAST && (SER_BYTE != ser_crc_q);
      if (SER_VALID) ser_crc_q <= SER_LAST ? dmh_pkg::CRC8_INIT : ser_crc_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      otp_crc_q <= dmh_pkg::CRC32_INIT;
      otp_err_q <= 1'b0;
    end else begin
      otp_err_q <= OTP_VALID && OTP_LAST && (OTP_WORD != otp_crc_q);
      if (OTP_VALID) otp_crc_q <= OTP_LAST ? dmh_pkg::CRC32_INIT : otp_crc_d;
    end
  end

  always_comb begin
    case (scr_idx_q)
      3'd0: scr_word = ctrl_q;
      3'd1: scr_word = mon_en_q;
      3'd2: scr_word = route_q;
      3'd3: scr_word = out_en_q;
      3'd4: scr_word = ppm_lim_q;
      default: scr_word = pin_sel_q;
    endcase
  end

  // The reference is relearned after any software write, but a write to a register already read in a running pass leaves a stale one that flags.
  always_ff @(posedge CLK) begin
    if (RST) begin
      scr_tmr_q <= '0;
      scr_idx_q <= '0;
      scr_run_q <= 1'b0;
      scr_crc_q <= dmh_pkg::CRC32_INIT;
      scr_ref_q <= dmh_pkg::CRC32_INIT;
      scr_dirty_q <= 1'b1;
      reg_err_q <= 1'b0;
    end else begin
      reg_err_q <= 1'b0;
      scr_tmr_q <= (scr_tmr_q == SCRUB_LAST) ? '0 : scr_tmr_q + 17'd1;
      if (wr_go) scr_dirty_q <= 1'b1;
      if (!scr_run_q && scr_tmr_q == SCRUB_LAST && ctrl_q[dmh_pkg::B_SCRUB]) begin
        scr_run_q <= 1'b1;
        scr_idx_q <= '0;
        scr_crc_q <= dmh_pkg::CRC32_INIT;
      end else if (scr_run_q) begin
        scr_crc_q <= scr_crc_d;
        scr_idx_q <= scr_idx_q + 3'd1;
        if (scr_idx_q == 3'(dmh_pkg::NSCRUB - 1)) begin
          scr_run_q <= 1'b0;
          if (scr_dirty_q && !wr_go) begin
            scr_ref_q <= scr_crc_d;
            scr_dirty_q <= 1'b0;
          end else if (!scr_dirty_q) begin
            reg_err_q <= scr_crc_d != scr_ref_q;
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Power-on self test: CRC engine check, then every monitor by insertion.

  typedef enum {PST_BIST, PST_WALK, PST_DONE} dmh_post_e;
  dmh_post_e post_q;
  logic [3:0] post_idx_q;

  assign post_done = post_q == PST_DONE;
  // Feeding a value its own CRC leaves zero; a nonzero seed over zero data does not.
  assign otp_c_in = post_done ? otp_crc_q : dmh_pkg::POST_PATTERN;
  assign otp_c_dat = post_done ? OTP_WORD : dmh_pkg::POST_PATTERN;
  assign scr_c_in = post_done ? scr_crc_q : dmh_pkg::POST_PATTERN;
  assign scr_c_dat = post_done ? scr_word : 32'h0000_0000;

  always_ff @(posedge CLK) begin
    if (RST) begin
      post_q <= PST_BIST;
      post_idx_q <= '0;
      post_fail_q <= 1'b0;
    end else begin
      case (post_q)
        PST_BIST: begin
          if (otp_crc_d != 32'h0000_0000 || scr_crc_d == 32'h0000_0000) post_fail_q <= 1'b1;
          post_q <= PST_WALK;
        end
        PST_WALK: begin
          if (!hit[post_idx_q]) post_fail_q <= 1'b1;
          post_idx_q <= post_idx_q + 4'd1;
          if (post_idx_q == 4'(NM - 1)) post_q <= PST_DONE;
        end
        PST_DONE: post_q <= PST_DONE;
        default: post_q <= PST_BIST;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Monitors, output checks and crystal switchover.

  logic los_act;
  assign los_act = active_q ? XTAL_LOS[1] : XTAL_LOS[0];
  assign raw[dmh_pkg::M_LOS] = los_act;
  assign raw[dmh_pkg::M_PPMW] = ctrl_q[dmh_pkg::B_DUAL] && PPM_DIFF > ppm_lim_q[15:0];
  assign raw[dmh_pkg::M_PPME] = ctrl_q[dmh_pkg::B_DUAL] && PPM_DIFF > ppm_lim_q[dmh_pkg::PPM_ERR_LSB +: 16];
  assign raw[dmh_pkg::M_LOCK] = !PLL_LOCK;
  assign raw[dmh_pkg::M_OUT] = |out_err_q;
  assign raw[dmh_pkg::M_SER] = ser_err_q;
  assign raw[dmh_pkg::M_OTP] = otp_err_q;
  assign raw[dmh_pkg::M_REG] = reg_err_q;
  assign raw[dmh_pkg::M_SWAP] = swap_ev;

  always_comb begin
    inj = inject_q[NM-1:0];
    if (post_q == PST_WALK) inj[post_idx_q] = 1'b1;
  end

  for (genvar m = 0; m < NM; m++) begin : g_mon
    dmh_flag u_flag (
      .clk(CLK), .rst(RST), .raw(raw[m]), .inject(inj[m]), .enable(mon_en_q[m]),
      .freeze(!post_done), .clear(clr_status[m]), .hit(hit[m]), .flag(flag[m]));
  end

  // Per-output error flags; a new error wins over a clear in the same cycle.
  always_ff @(posedge CLK) begin
    if (RST) begin
      out_err_q <= '0;
    end else if (post_done) begin
      out_err_q <= (out_err_q & ~clr_out) | (out_en_q[NO-1:0] & {NO{ctrl_q[dmh_pkg::B_FCHK]}} &
                   (OUT_FREQ_ERR | inject_q[dmh_pkg::OUT_INJ_LSB +: NO]));
    end
  end

  assign swap_ev = post_done && ctrl_q[dmh_pkg::B_DUAL] && hit[dmh_pkg::M_LOS] &&
                   !(active_q ? XTAL_LOS[0] : XTAL_LOS[1]);

  // Swaps both ways: only a hit on the active crystal's loss monitor, real or inserted, moves the mux.
  always_ff @(posedge CLK) begin
    if (RST) begin
      active_q <= 1'b0;
    end else if (swap_ev) begin
      active_q <= !active_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Alert routing, fail-safe and pins.

  always_comb begin
    notify_act = 1'b0;
    safe_act = 1'b0;
    for (int m = 0; m < NM; m++) begin
      if (flag[m] && mon_en_q[m] && route_q[2*m +: 2] == dmh_pkg::RT_NOTIFY) notify_act = 1'b1;
      if (flag[m] && mon_en_q[m] && route_q[2*m +: 2] == dmh_pkg::RT_SAFE) safe_act = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      CLK_OE <= '0;
      XTAL_SEL <= 1'b0;
    end else begin
      CLK_OE <= (post_done && !safe_act) ? out_en_q[NO-1:0] &
                ~(out_err_q & {NO{ctrl_q[dmh_pkg::B_SHUT]}}) : '0;
      XTAL_SEL <= active_q;
    end
  end

  // Out-of-range selects park the function; both functions may share one pin.
  always_ff @(posedge CLK) begin
    if (RST) begin
      GPIO_OE <= '0;
    end else begin
      for (int p = 0; p < NGPIO; p++) begin
        GPIO_OE[p] <= (pin_sel_q[dmh_pkg::SAFE_PIN_LSB +: 3] == 3'(p) && safe_act) ||
                      (pin_sel_q[2:0] == 3'(p) && notify_act);
      end
    end
  end
  assign GPIO_O = '0;
endmodule : dmh_top
`default_nettype wire

// >>> hdl/dmh_pkg.sv
/*
 Shared constants of the diagnostic monitor hub: register map, field layout,
 reset values, monitor numbering, CRC settings and timing.
 Assumes nothing of its surroundings.
*/
package dmh_pkg;
  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_MON_EN = 8'h04;
  localparam logic [7:0] A_ROUTE = 8'h08;
  localparam logic [7:0] A_INJECT = 8'h0c;
  localparam logic [7:0] A_STATUS = 8'h10;
  localparam logic [7:0] A_OUT_EN = 8'h14;
  localparam logic [7:0] A_OUT_ERR = 8'h18;
  localparam logic [7:0] A_PPM_LIM = 8'h1c;
  localparam logic [7:0] A_PIN_SEL = 8'h20;
  localparam logic [7:0] A_STATE = 8'h24;
  // Control register bits.
  localparam int B_DUAL = 0;
  localparam int B_SHUT = 1;
  localparam int B_FCHK = 2;
  localparam int B_SCRUB = 3;
  // State register bits.
  localparam int B_ACT = 0;
  localparam int B_SAFE = 1;
  localparam int B_PDONE = 2;
  localparam int B_PFAIL = 3;
  localparam int B_LOCK = 4;
  // Monitor numbering.
  localparam int NMON = 9;
  localparam int M_LOS = 0;
  localparam int M_PPMW = 1;
  localparam int M_PPME = 2;
  localparam int M_LOCK = 3;
  localparam int M_OUT = 4;
  localparam int M_SER = 5;
  localparam int M_OTP = 6;
  localparam int M_REG = 7;
  localparam int M_SWAP = 8;
  localparam int NOUT = 12;
  localparam int NGPIO = 7;
  localparam int OUT_INJ_LSB = 16;
  localparam int PPM_ERR_LSB = 16;
  localparam int SAFE_PIN_LSB = 4;
  // Route codes, two bits per monitor.
  typedef enum logic [1:0] {RT_NONE, RT_NOTIFY, RT_SAFE, RT_RSVD} dmh_route_e;
  // Reset values.
  localparam logic [31:0] RST_CTRL = 32'h0000_0006;
  localparam logic [31:0] RST_MON_EN = 32'h0000_0000;
  localparam logic [31:0] RST_ROUTE = 32'h0000_0000;
  localparam logic [31:0] RST_OUT_EN = 32'h0000_0fff;
  localparam logic [31:0] RST_PPM_LIM = 32'h00c8_0064;
  localparam logic [31:0] RST_PIN_SEL = 32'h0000_0010;
  // CRC engines; polynomial and seed values are plain defaults.
  localparam logic [7:0] CRC8_POLY = 8'h07;
  localparam logic [7:0] CRC8_INIT = 8'h00;
  localparam logic [31:0] CRC32_POLY = 32'h04c1_1db7;
  localparam logic [31:0] CRC32_INIT = 32'hffff_ffff;
  localparam logic [31:0] POST_PATTERN = 32'h5a5a_c3c3;
  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Timing.
  localparam int CLK_HZ = 10_000_000;
  localparam int SCRUB_PERIOD_MS = 10;
  localparam int SCRUB_CYCLES = SCRUB_PERIOD_MS * (CLK_HZ / 1000);
  localparam int NSCRUB = 6;
endpackage : dmh_pkg

// >>> hdl/dmh_crc.sv
/*
 One combinational CRC update step, MSB first, non reflected.
 Assumes the caller holds the running value in its own register.
*/
`timescale 1ns/1ps
`default_nettype none
module dmh_crc #(
  parameter int CW = 8,
  parameter int DW = 8,
  parameter logic [CW-1:0] POLY = '0
) (
  // Running value and new data.
  input wire logic [CW-1:0] crc_in,
  input wire logic [DW-1:0] data,
  // Updated value.
  output logic [CW-1:0] crc_out
);
  logic [CW-1:0] c;
  logic fb;

  always_comb begin
    c = crc_in;
    fb = 1'b0;
    for (int i = DW - 1; i >= 0; i--) begin
      fb = c[CW-1] ^ data[i];
      c = {c[CW-2:0], 1'b0};
      if (fb) begin
        c = c ^ POLY;
      end
    end
    crc_out = c;
  end
endmodule : dmh_crc
`default_nettype wire

// >>> hdl/dmh_flag.sv
/*
 One monitor cell: merges the raw condition with fault insertion and keeps a
 sticky status flag. Assumes a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module dmh_flag (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Condition, insertion and control.
  input wire logic raw,
  input wire logic inject,
  input wire logic enable,
  input wire logic freeze,
  input wire logic clear,
  // Results.
  output logic hit,
  output logic flag
);
  logic flag_q;

  assign hit = raw | inject;
  assign flag = flag_q;

  // A new hit in the clearing cycle keeps the flag set.
  always_ff @(posedge clk) begin
    if (rst) begin
      flag_q <= 1'b0;
    end else if (enable && hit && !freeze) begin
      flag_q <= 1'b1;
    end else if (clear) begin
      flag_q <= 1'b0;
    end
  end
endmodule : dmh_flag
`default_nettype wire

// >>> test/dmh_soc_model.sv
/*
 Far-side host model: pull-ups on the open-drain alert pins, plus the
 host's CRC for serial accesses. Assumes the hub's GPIO_O and GPIO_OE.
*/
`timescale 1ns/1ps
`default_nettype none
module dmh_soc_model (
  // Hub drive.
  input wire logic [6:0] gpio_o,
  input wire logic [6:0] gpio_oe,
  // Resolved pin levels.
  output logic [6:0] pin
);
  // A released pin floats up to the pull-up level.
  assign pin = (gpio_oe & gpio_o) | ~gpio_oe;

  // The host appends this byte so the hub can check the access.
  function automatic logic [7:0] crc8(input logic [7:0] d);
    logic [7:0] c;
    c = d;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ({c[6:0], 1'h0} ^ dmh_pkg::CRC8_POLY) : {c[6:0], 1'h0};
    end
    return c;
  endfunction : crc8
endmodule : dmh_soc_model
`default_nettype wire

// >>> test/dmh_props.sv
/*
 Checker for the hub's alert pins, clock enables and bus handshakes.
 Assumes it is bound to dmh_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module dmh_props (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RST,
  // Bus.
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Pins.
  input wire logic XTAL_SEL,
  input wire logic [11:0] CLK_OE,
  input wire logic [6:0] GPIO_O,
  input wire logic [6:0] GPIO_OE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  a_drain_only: assert property (GPIO_O == 7'h00)
    else $error("alert pin driven high");
  a_post_quiet: assert property ($fell(RST) |-> ((CLK_OE == 12'h000 && GPIO_OE == 7'h00 && !XTAL_SEL) [*8]))
    else $error("outputs active during self test");
  a_safe_blank: assert property (GPIO_OE[1] |-> CLK_OE == 12'h000)
    else $error("clock output on in safe state");
  // An alert only drops after a register write or a reset.
  a_alert_hold: assert property ((($past(GPIO_OE[1:0]) & ~GPIO_OE[1:0]) != 2'h0) |->
    $past(S_AXI_BVALID) || $past(S_AXI_BVALID, 2) || $past(RST))
    else $error("alert released without clear");
  a_read_turn: assert property (S_AXI_ARVALID && !S_AXI_RVALID |=> S_AXI_RVALID)
    else $error("read answer late");
  a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data not held");
  a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response not held");
  a_write_turn: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
    |-> ##[1:2] S_AXI_BVALID)
    else $error("write answer late");
  c_safe: cover property (GPIO_OE[1]);
  c_swap: cover property ($rose(XTAL_SEL));
  c_slverr: cover property (S_AXI_BVALID && S_AXI_BRESP == 2'h2);
endmodule : dmh_props
bind dmh_top dmh_props dmh_props_inst (.CLK(CLK), .RST(RST), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .XTAL_SEL(XTAL_SEL), .CLK_OE(CLK_OE), .GPIO_O(GPIO_O), .GPIO_OE(GPIO_OE));
`default_nettype wire

// >>> test/dmh_tb_top.sv
/*
 Directed bench for the hub: AXI4-Lite tasks and monitor scenarios.
 Assumes dmh_pkg, dmh_top and the host pad model.
*/
`timescale 1ns/1ps
`default_nettype none
module dmh_tb_top;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, sb = 8'h00;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0, ow = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid, xsel;
  logic [1:0] bresp, rresp, los = 2'h0;
  logic [15:0] ppm = 16'h0000;
  logic lock = 1'h1, sv = 1'h0, sl = 1'h0, ov = 1'h0, ol = 1'h0;
  logic [11:0] ferr = 12'h000, oe;
  logic [6:0] go, goe, pin;
  int error_cnt = 0, n_checks = 0;
  initial forever #50 clk = ~clk;
  // A short scrub period keeps the register check inside the run.
  dmh_top #(.SCRUB_CYCLES(64)) dmh_top_inst (.CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .XTAL_LOS(los), .PPM_DIFF(ppm), .PLL_LOCK(lock), .OUT_FREQ_ERR(ferr), .SER_VALID(sv),
    .SER_BYTE(sb), .SER_LAST(sl), .OTP_VALID(ov), .OTP_WORD(ow), .OTP_LAST(ol),
    .XTAL_SEL(xsel), .CLK_OE(oe), .GPIO_O(go), .GPIO_OE(goe));
  dmh_soc_model dmh_soc_model_inst (.gpio_o(go), .gpio_oe(goe), .pin(pin));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask : tick
  // Ready is raised only after the answer shows, so the hold is exercised.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    forever begin
      @(posedge clk);
      n++;
      if ((bvalid && bready) || n == 50) break;
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      bready <= bvalid;
    end
    bready <= 1'h0;
    chk(32'(n < 50), 32'h1);
    chk(32'(bresp), a > dmh_pkg::A_STATE ? 32'(dmh_pkg::RESP_SLVERR) : 32'(dmh_pkg::RESP_OKAY));
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    int n = 0;
    araddr <= a;
    arvalid <= 1'h1;
    forever begin
      @(posedge clk);
      n++;
      if ((rvalid && rready) || n == 50) break;
      if (arready) arvalid <= 1'h0;
      rready <= rvalid;
    end
    rready <= 1'h0;
    chk(rdata, e);
    chk(32'(rresp), a > dmh_pkg::A_STATE ? 32'(dmh_pkg::RESP_SLVERR) : 32'(dmh_pkg::RESP_OKAY));
  endtask : rc
  task automatic summarize;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    tick(15);
    rc(dmh_pkg::A_STATE, 32'h14);
    rc(dmh_pkg::A_CTRL, dmh_pkg::RST_CTRL);
    rc(dmh_pkg::A_OUT_EN, dmh_pkg::RST_OUT_EN);
    rc(dmh_pkg::A_PPM_LIM, dmh_pkg::RST_PPM_LIM);
    rc(dmh_pkg::A_PIN_SEL, dmh_pkg::RST_PIN_SEL);
    rc(8'h28, 32'h0);
    wr(8'h28, 32'h1);
    wr(dmh_pkg::A_STATE, 32'h0);
    rc(dmh_pkg::A_STATE, 32'h14);
    $display("test registers done");
    lock <= 1'h0;
    tick(5);
    chk(32'(goe), 32'h0);
    rc(dmh_pkg::A_STATUS, 32'h0);
    for (int c = 0; c < 3; c++) begin
      lock <= 1'h0;
      wr(dmh_pkg::A_ROUTE, 32'(c) << 6);
      wr(dmh_pkg::A_MON_EN, 32'h8);
      tick(4);
      chk(32'(goe), 32'(c));
      chk(32'(oe), c == 2 ? 32'h0 : 32'hfff);
      chk(32'(pin[1]), c == 2 ? 32'h0 : 32'h1);
      rc(dmh_pkg::A_STATUS, 32'h8);
      lock <= 1'h1;
      tick(4);
      chk(32'(goe), 32'(c));
      wr(dmh_pkg::A_STATUS, 32'h1ff);
      tick(3);
      chk(32'(goe), 32'h0);
      chk(32'(oe), 32'hfff);
    end
    wr(dmh_pkg::A_ROUTE, 32'h0);
    wr(dmh_pkg::A_MON_EN, 32'h1ff);
    $display("test routing done");
    for (int m = 0; m < dmh_pkg::NMON; m++) begin
      wr(dmh_pkg::A_INJECT, 32'h1 << m);
      tick(2);
      wr(dmh_pkg::A_INJECT, 32'h0);
      rc(dmh_pkg::A_STATUS, 32'h1 << m);
      wr(dmh_pkg::A_OUT_ERR, 32'hfff);
      wr(dmh_pkg::A_STATUS, 32'h1ff);
    end
    $display("test insertion done");
    ferr <= 12'h020;
    tick(4);
    ferr <= 12'h000;
    chk(32'(oe), 32'hfdf);
    rc(dmh_pkg::A_OUT_ERR, 32'h20);
    wr(dmh_pkg::A_OUT_ERR, 32'h20);
    wr(dmh_pkg::A_STATUS, 32'h1ff);
    $display("test output check done");
    sv <= 1'h1;
    for (int k = 0; k < 4; k++) begin
      sb <= k[0] ? dmh_soc_model_inst.crc8(8'h01) ^ {8{k[1]}} : 8'h01;
      sl <= k[0];
      @(posedge clk);
    end
    sv <= 1'h0;
    sl <= 1'h0;
    ov <= 1'h1;
    ol <= 1'h0;
    @(posedge clk);
    ol <= 1'h1;
    @(posedge clk);
    ov <= 1'h0;
    ol <= 1'h0;
    tick(4);
    rc(dmh_pkg::A_STATUS, 32'h60);
    wr(dmh_pkg::A_STATUS, 32'h1ff);
    $display("test crc done");
    wr(dmh_pkg::A_CTRL, 32'h7);
    ppm <= 16'd150;
    tick(4);
    rc(dmh_pkg::A_STATUS, 32'h2);
    ppm <= 16'd250;
    tick(4);
    rc(dmh_pkg::A_STATUS, 32'h6);
    ppm <= 16'h0000;
    wr(dmh_pkg::A_STATUS, 32'h1ff);
    los <= 2'h1;
    tick(5);
    chk(32'(xsel), 32'h1);
    los <= 2'h0;
    tick(10);
    chk(32'(xsel), 32'h1);
    rc(dmh_pkg::A_STATUS, 32'h101);
    $display("test crystal done");
    wr(dmh_pkg::A_CTRL, 32'hf);
    tick(200);
    rc(dmh_pkg::A_STATUS, 32'h101);
    $display("test scrub done");
    summarize();
  end
  initial begin
    repeat (6000) @(posedge clk);
    error_cnt++;
    $display("[ERR] t=%0t watchdog %h %h", $time, n_checks, error_cnt);
    summarize();
  end
endmodule : dmh_tb_top
`default_nettype wire
